// [verilog/flow_ctl_pkg.sv]
package flow_ctl_pkg;
    // Pause code field and its meanings
    localparam int CODE_W = 4;
    localparam logic [CODE_W-1:0] RESUME_CODE = 4'h0;
    localparam logic [CODE_W-1:0] MAX_PAUSE_CODE = 4'h8;
    localparam logic [CODE_W-1:0] HALT_CODE = 4'hF;
    // Idle beat counter wide enough for 256
    localparam int IDLE_W = 9;
    localparam logic [IDLE_W-1:0] NO_IDLES = 9'h000;
    localparam logic [IDLE_W-1:0] ONE_IDLE = 9'h001;

    // Controller register map on the plain port
    localparam int ADDR_W = 8;
    localparam int REG_W = 32;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;
    localparam logic [ADDR_W-1:0] INT_STATUS_ADDR = 8'h08;
    localparam logic [ADDR_W-1:0] INT_MASK_ADDR = 8'h0C;
    localparam logic [ADDR_W-1:0] FRAME_LEN_ADDR = 8'h10;
    // CTRL fields
    localparam int CTRL_CODE_LSB = 0;
    localparam int CTRL_SEND_BIT = 8;
    localparam int CTRL_GEN_BIT = 9;
    // STATUS fields
    localparam int ST_LINK_BIT = 0;
    localparam int ST_PEND_BIT = 1;
    localparam int ST_RXCODE_LSB = 4;
    localparam int ST_LANES_LSB = 8;
    localparam int MAX_LANES = 16;
    // Interrupt event bits
    localparam int EV_MSG_BIT = 0;
    localparam int EV_FERR_BIT = 1;
    localparam int EV_ACK_BIT = 2;
    localparam int EV_W = 3;
    // Frame generator length
    localparam int LEN_W = 16;
    localparam logic [LEN_W-1:0] FRAME_LEN_RST = 16'h0010;
    localparam logic [LEN_W-1:0] FRAME_LEN_MIN = 16'h0001;

    // Codes 1..8 ask for 2**code idle beats
    function automatic logic [IDLE_W-1:0] idle_beats(input logic [CODE_W-1:0] code);
        idle_beats = ONE_IDLE << code;
    endfunction : idle_beats
endpackage : flow_ctl_pkg

// [verilog/flow_if.sv]
`timescale 1ns/10ps
interface flow_if #(
    parameter int LANES = 1,
    parameter int DATA_W = 32,
    parameter bit BIG_ENDIAN = 1'b0
) ();
    localparam int CODE_HI = BIG_ENDIAN ? 0 : flow_ctl_pkg::CODE_W - 1;
    localparam int CODE_LO = BIG_ENDIAN ? flow_ctl_pkg::CODE_W - 1 : 0;

    logic flow_request;
    logic [CODE_HI:CODE_LO] pause_code_out;
    logic flow_request_accept;
    logic [DATA_W-1:0] tx_data;
    logic tx_valid;
    logic tx_last;
    logic tx_accept_ready;
    logic flow_message_seen;
    logic [CODE_HI:CODE_LO] received_pause_code;
    logic link_operational;
    logic [LANES-1:0] lane_operational;
    logic framing_error_pulse;

    modport device_end (
        input flow_request, pause_code_out, tx_data, tx_valid, tx_last,
        output flow_request_accept, tx_accept_ready, flow_message_seen,
        output received_pause_code, link_operational, lane_operational,
        output framing_error_pulse
    );
    modport user_end (
        output flow_request, pause_code_out, tx_data, tx_valid, tx_last,
        input flow_request_accept, tx_accept_ready, flow_message_seen,
        input received_pause_code, link_operational, lane_operational,
        input framing_error_pulse
    );
endinterface : flow_if

// [verilog/native_flow_control_port.sv]
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
module native_flow_control_port #(
    parameter int LANES = 1,
    parameter int DATA_W = 32,
    parameter bit NFC_ENABLE = 1'b1,
    parameter bit FULL_DUPLEX = 1'b1,
    parameter bit IMMEDIATE_MODE = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    flow_if.device_end fc,
    input wire logic channel_init_done,
    input wire logic [LANES-1:0] lane_init_done,
    input wire logic rx_msg_valid,
    input wire logic [flow_ctl_pkg::CODE_W-1:0] rx_msg_code,
    input wire logic link_error_detect,
    output logic link_msg_send,
    output logic [flow_ctl_pkg::CODE_W-1:0] link_msg_code,
    output logic link_data_valid,
    output logic [DATA_W-1:0] link_data,
    output logic link_data_last
);
    import flow_ctl_pkg::*;

    if (LANES < 1 || DATA_W < 1) begin : g_bad_width
        $error("native_flow_control_port: LANES and DATA_W must be at least 1");
    end
    if (NFC_ENABLE && !FULL_DUPLEX) begin : g_bad_mode
        $error("native_flow_control_port: flow control needs a full-duplex build");
    end

    // Flow-control logic is present only in a full-duplex build with it enabled
    localparam bit FC_ON = NFC_ENABLE && FULL_DUPLEX;

    logic [CODE_W-1:0] req_code;
    logic fire;

    // Request side state
    logic accept;
    logic next_accept;
    logic send;
    logic next_send;
    logic [CODE_W-1:0] send_code;
    logic [CODE_W-1:0] next_send_code;

    // Transmit throttle state
    logic ready;
    logic next_ready;
    logic idling;
    logic next_idling;
    logic halted;
    logic next_halted;
    logic frame_open;
    logic next_frame_open;
    logic [IDLE_W-1:0] idle_left;
    logic [IDLE_W-1:0] next_idle_left;
    logic data_valid;
    logic next_data_valid;
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] next_data;
    logic data_last;
    logic next_data_last;

    // Receive and status state
    logic msg_seen;
    logic next_msg_seen;
    logic [CODE_W-1:0] rx_code;
    logic [CODE_W-1:0] next_rx_code;
    logic link_up;
    logic next_link_up;
    logic [LANES-1:0] lanes_up;
    logic [LANES-1:0] next_lanes_up;
    logic ferr;
    logic next_ferr;

    // Positional copy: same value for either bit numbering
    assign req_code = fc.pause_code_out;
    assign fire = fc.tx_valid && ready;

    // Request side
    always_comb begin
        next_accept = 1'b0;
        if (FC_ON && link_up && fc.flow_request && !accept) begin
            next_accept = 1'b1;
        end
        // Code is still held while acknowledge is high
        next_send = accept;
        next_send_code = accept ? req_code : send_code;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            accept <= 1'b0;
            send <= 1'b0;
            send_code <= RESUME_CODE;
        end else begin
            accept <= next_accept;
            send <= next_send;
            send_code <= next_send_code;
        end
    end

    // Transmit throttle
    always_comb begin
        next_frame_open = frame_open;
        if (fire) begin
            next_frame_open = !fc.tx_last;
        end
        next_halted = halted;
        next_idle_left = idle_left;
        if (idling && idle_left != NO_IDLES) begin
            next_idle_left = idle_left - ONE_IDLE;
        end
        if (FC_ON && rx_msg_valid) begin
            if (rx_msg_code == RESUME_CODE) begin
                next_halted = 1'b0;
                next_idle_left = NO_IDLES;
            end else if (rx_msg_code == HALT_CODE) begin
                next_halted = 1'b1;
            end else if (rx_msg_code <= MAX_PAUSE_CODE) begin
                // Keep the longer of old and new request
                if (idle_beats(rx_msg_code) > next_idle_left) begin
                    next_idle_left = idle_beats(rx_msg_code);
                end
            end
        end
        next_idling = link_up && (halted || idle_left != NO_IDLES)
            && (IMMEDIATE_MODE || !next_frame_open);
        // One-cycle gap after acknowledge carries the outgoing message
        next_ready = next_link_up && !accept && !next_idling;
        next_data_valid = fire;
        next_data = fire ? fc.tx_data : data;
        next_data_last = fire && fc.tx_last;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ready <= 1'b0;
            idling <= 1'b0;
            halted <= 1'b0;
            frame_open <= 1'b0;
            idle_left <= NO_IDLES;
            data_valid <= 1'b0;
            data <= '0;
            data_last <= 1'b0;
        end else begin
            ready <= next_ready;
            idling <= next_idling;
            halted <= next_halted;
            frame_open <= next_frame_open;
            idle_left <= next_idle_left;
            data_valid <= next_data_valid;
            data <= next_data;
            data_last <= next_data_last;
        end
    end

    // Receive and channel status
    always_comb begin
        next_msg_seen = FC_ON && rx_msg_valid;
        next_rx_code = (FC_ON && rx_msg_valid) ? rx_msg_code : rx_code;
        next_link_up = channel_init_done;
        next_lanes_up = lane_init_done;
        next_ferr = link_error_detect;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            msg_seen <= 1'b0;
            rx_code <= RESUME_CODE;
            link_up <= 1'b0;
            lanes_up <= '0;
            ferr <= 1'b0;
        end else begin
            msg_seen <= next_msg_seen;
            rx_code <= next_rx_code;
            link_up <= next_link_up;
            lanes_up <= next_lanes_up;
            ferr <= next_ferr;
        end
    end

    assign fc.flow_request_accept = accept;
    assign fc.tx_accept_ready = ready;
    assign fc.flow_message_seen = msg_seen;
    assign fc.received_pause_code = rx_code;
    assign fc.link_operational = link_up;
    assign fc.lane_operational = lanes_up;
    assign fc.framing_error_pulse = ferr;
    assign link_msg_send = send;
    assign link_msg_code = send_code;
    assign link_data_valid = data_valid;
    assign link_data = data;
    assign link_data_last = data_last;
endmodule : native_flow_control_port

// [verilog/flow_user_end.sv]
`timescale 1ns/10ps
module flow_user_end #(
    parameter int LANES = 1,
    parameter int DATA_W = 32
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    flow_if.user_end fc,
    input wire logic [flow_ctl_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [flow_ctl_pkg::REG_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [flow_ctl_pkg::REG_W-1:0] reg_rdata,
    output logic irq
);
    import flow_ctl_pkg::*;

    if (LANES < 1 || LANES > MAX_LANES || DATA_W < 1) begin : g_bad_width
        $error("flow_user_end: LANES must be 1..16 and DATA_W at least 1");
    end

    typedef enum logic [0:0] {REQ_IDLE, REQ_WAIT} req_state_t;

    req_state_t req_state;
    req_state_t next_req_state;
    logic request;
    logic next_request;
    logic [CODE_W-1:0] req_code;
    logic [CODE_W-1:0] next_req_code;
    logic gen_enable;
    logic next_gen_enable;
    logic [LEN_W-1:0] frame_len;
    logic [LEN_W-1:0] next_frame_len;
    logic [LEN_W-1:0] beat_cnt;
    logic [LEN_W-1:0] next_beat_cnt;
    logic tx_valid;
    logic next_tx_valid;
    logic tx_last;
    logic next_tx_last;
    logic [DATA_W-1:0] tx_data;
    logic [DATA_W-1:0] next_tx_data;
    logic [EV_W-1:0] int_status;
    logic [EV_W-1:0] next_int_status;
    logic [EV_W-1:0] int_mask;
    logic [EV_W-1:0] next_int_mask;
    logic [REG_W-1:0] next_rdata;
    logic next_irq;

    logic wr_ctrl;
    logic [CODE_W-1:0] wr_code;
    logic code_ok;
    logic fire;
    logic [EV_W-1:0] events;

    assign wr_ctrl = reg_write && reg_addr == CTRL_ADDR;
    assign wr_code = reg_wdata[CTRL_CODE_LSB +: CODE_W];
    assign code_ok = wr_code <= MAX_PAUSE_CODE || wr_code == HALT_CODE;
    assign fire = tx_valid && fc.tx_accept_ready;

    always_comb begin
        next_req_state = req_state;
        next_req_code = req_code;
        case (req_state)
            REQ_IDLE: begin
                // Reserved codes are never launched
                if (wr_ctrl && reg_wdata[CTRL_SEND_BIT] && code_ok) begin
                    next_req_state = REQ_WAIT;
                    next_req_code = wr_code;
                end
            end
            REQ_WAIT: begin
                if (fc.flow_request_accept) begin
                    next_req_state = REQ_IDLE;
                end
            end
            default: next_req_state = REQ_IDLE;
        endcase
        next_request = next_req_state == REQ_WAIT;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            req_state <= REQ_IDLE;
            request <= 1'b0;
            req_code <= RESUME_CODE;
        end else begin
            req_state <= next_req_state;
            request <= next_request;
            req_code <= next_req_code;
        end
    end

    // Frame generator: a frame already begun always runs to its last beat
    always_comb begin
        next_gen_enable = wr_ctrl ? reg_wdata[CTRL_GEN_BIT] : gen_enable;
        next_frame_len = frame_len;
        if (reg_write && reg_addr == FRAME_LEN_ADDR) begin
            next_frame_len = (reg_wdata[LEN_W-1:0] == '0) ? FRAME_LEN_MIN
                : reg_wdata[LEN_W-1:0];
        end
        next_beat_cnt = beat_cnt;
        next_tx_data = tx_data;
        if (fire) begin
            next_beat_cnt = tx_last ? '0 : beat_cnt + 1'b1;
            next_tx_data = tx_data + 1'b1;
        end
        next_tx_valid = gen_enable || (tx_valid && !(fire && tx_last));
        next_tx_last = next_beat_cnt == frame_len - FRAME_LEN_MIN;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            gen_enable <= 1'b0;
            frame_len <= FRAME_LEN_RST;
            beat_cnt <= '0;
            tx_valid <= 1'b0;
            tx_last <= 1'b0;
            tx_data <= '0;
        end else begin
            gen_enable <= next_gen_enable;
            frame_len <= next_frame_len;
            beat_cnt <= next_beat_cnt;
            tx_valid <= next_tx_valid;
            tx_last <= next_tx_last;
            tx_data <= next_tx_data;
        end
    end

    // Registers, sticky events and interrupt; a new event beats the read clear
    always_comb begin
        events = '0;
        events[EV_MSG_BIT] = fc.flow_message_seen;
        events[EV_FERR_BIT] = fc.framing_error_pulse;
        events[EV_ACK_BIT] = fc.flow_request_accept;
        next_int_status = int_status;
        if (reg_read && reg_addr == INT_STATUS_ADDR) begin
            next_int_status = '0;
        end
        next_int_status = next_int_status | events;
        next_int_mask = int_mask;
        if (reg_write && reg_addr == INT_MASK_ADDR) begin
            next_int_mask = reg_wdata[EV_W-1:0];
        end
        next_irq = |(next_int_status & next_int_mask);
        next_rdata = '0;
        if (reg_read) begin
            case (reg_addr)
                CTRL_ADDR: begin
                    next_rdata[CTRL_CODE_LSB +: CODE_W] = req_code;
                    next_rdata[CTRL_GEN_BIT] = gen_enable;
                end
                STATUS_ADDR: begin
                    next_rdata[ST_LINK_BIT] = fc.link_operational;
                    next_rdata[ST_PEND_BIT] = request;
                    next_rdata[ST_RXCODE_LSB +: CODE_W] = fc.received_pause_code;
                    next_rdata[ST_LANES_LSB +: LANES] = fc.lane_operational;
                end
                INT_STATUS_ADDR: next_rdata[EV_W-1:0] = int_status;
                INT_MASK_ADDR: next_rdata[EV_W-1:0] = int_mask;
                FRAME_LEN_ADDR: next_rdata[LEN_W-1:0] = frame_len;
                default: next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            int_status <= '0;
            int_mask <= '0;
            irq <= 1'b0;
            reg_rdata <= '0;
        end else begin
            int_status <= next_int_status;
            int_mask <= next_int_mask;
            irq <= next_irq;
            reg_rdata <= next_rdata;
        end
    end

    assign fc.flow_request = request;
    assign fc.pause_code_out = req_code;
    assign fc.tx_valid = tx_valid;
    assign fc.tx_last = tx_last;
    assign fc.tx_data = tx_data;
endmodule : flow_user_end

// [dv/flow_checker.sv]
`timescale 1ns/10ps
module flow_checker (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic flow_request,
    input wire logic flow_request_accept,
    input wire logic tx_accept_ready,
    input wire logic flow_message_seen,
    input wire logic [3:0] received_pause_code,
    input wire logic link_operational,
    input wire logic framing_error_pulse
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    accept_pulse_a: assert property (flow_request_accept |=> !flow_request_accept)
        else $error("accept held past one cycle");
    accept_cause_a: assert property (flow_request_accept |-> flow_request && $past(link_operational))
        else $error("accept without request or link");
    accept_prompt_a: assert property ($rose(flow_request) && link_operational |-> ##[1:2] flow_request_accept)
        else $error("request not accepted in time");
    ready_gap_a: assert property (flow_request_accept |=> !tx_accept_ready)
        else $error("ready high after accept");
    seen_pulse_a: assert property (flow_message_seen |=> !flow_message_seen)
        else $error("message pulse too long");
    pause_two_a: assert property (flow_message_seen && received_pause_code == 4'h1 && link_operational
        |-> ##[0:2] !tx_accept_ready [*2])
        else $error("short pause too short");
    halt_hold_a: assert property (flow_message_seen && received_pause_code == 4'hF && link_operational
        |-> ##[1:3] !tx_accept_ready [*8])
        else $error("halt did not stop data");
    ferr_pulse_a: assert property (framing_error_pulse |=> !framing_error_pulse)
        else $error("framing error pulse too long");

    accept_c: cover property (flow_request_accept);
    halt_c: cover property (flow_message_seen && received_pause_code == 4'hF);
    ferr_c: cover property (framing_error_pulse);
endmodule : flow_checker

// [dv/native_flow_control_port_bench.sv]
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module native_flow_control_port_bench;
    import flow_ctl_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic channel_init_done = 1'b0;
    logic [0:0] lane_init_done = 1'b0;
    logic rx_msg_valid = 1'b0;
    logic [3:0] rx_msg_code = 4'h0;
    logic link_error_detect = 1'b0;
    logic link_msg_send;
    logic [3:0] link_msg_code;
    logic link_data_valid;
    logic [31:0] link_data;
    logic link_data_last;
    logic [ADDR_W-1:0] reg_addr = 8'h00;
    logic [REG_W-1:0] reg_wdata = 32'h00000000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [REG_W-1:0] reg_rdata;
    logic irq;
    int n_mismatch = 0;
    int n_compared = 0;
    int frame_len;
    int beats = 0;
    bit have_data = 0;
    logic [31:0] last_data;
    logic [15:0] lfsr = 16'hF503;
    logic [3:0] code_q[$];
    logic [3:0] exp_code;
    logic [31:0] rd;

    always #5 clk_sys = ~clk_sys;

    flow_if fc ();
    native_flow_control_port #(.IMMEDIATE_MODE(1'b1)) native_flow_control_port_inst (
        .clk_sys(clk_sys), .rst_n(rst_n),
        .fc(fc), .channel_init_done(channel_init_done), .lane_init_done(lane_init_done),
        .rx_msg_valid(rx_msg_valid), .rx_msg_code(rx_msg_code),
        .link_error_detect(link_error_detect), .link_msg_send(link_msg_send),
        .link_msg_code(link_msg_code), .link_data_valid(link_data_valid),
        .link_data(link_data), .link_data_last(link_data_last));
    flow_user_end flow_user_end_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .fc(fc), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq));
    flow_checker flow_checker_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .flow_request(fc.flow_request), .flow_request_accept(fc.flow_request_accept),
        .tx_accept_ready(fc.tx_accept_ready), .flow_message_seen(fc.flow_message_seen),
        .received_pause_code(fc.received_pause_code), .link_operational(fc.link_operational),
        .framing_error_pulse(fc.framing_error_pulse));

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk_sys);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1 rd = reg_rdata;
    endtask : rd_reg

    // Launch a message, keeping the frame generator enabled
    task automatic send(input logic [3:0] c);
        int i;
        code_q.push_back(c);
        wr(CTRL_ADDR, {22'h000000, 1'b1, 1'b1, 4'h0, c});
        for (i = 0; i < 10 && code_q.size() > 0; i++) @(posedge clk_sys);
        `CHK("sent", 0, code_q.size())
    endtask : send

    task automatic recv(input logic [3:0] c);
        @(posedge clk_sys);
        rx_msg_valid <= 1'b1;
        rx_msg_code <= c;
        @(posedge clk_sys);
        rx_msg_valid <= 1'b0;
        #1;
        `CHK("seen", 1'b1, fc.flow_message_seen)
        `CHK("rx code", c, fc.received_pause_code)
    endtask : recv

    // Count cycles with ready low until ready comes back
    task automatic idles(input int min_low);
        int i;
        int low;
        low = 0;
        for (i = 0; i < 600; i++) begin
            @(posedge clk_sys);
            #1;
            if (fc.tx_accept_ready === 1'b0) low++;
            else if (low > 0 || i > 4) break;
        end
        `CHK("idles", 1'b1, low >= min_low && i < 600)
    endtask : idles

    task automatic wrap_up();
        if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up

    always @(negedge clk_sys) begin
        if (rst_n && link_msg_send) begin
            `CHK("pending", 1'b1, code_q.size() > 0)
            if (code_q.size() > 0) exp_code = code_q.pop_front();
            `CHK("msg code", exp_code, link_msg_code)
        end
        if (rst_n && link_data_valid) begin
            if (have_data) `CHK("data step", last_data + 32'h1, link_data)
            last_data = link_data;
            have_data = 1;
            beats++;
            if (link_data_last) begin
                `CHK("frame len", frame_len, beats)
                beats = 0;
            end
        end
    end

    initial begin
        int k;
        int low;
        lfsr = lfsr_next(lfsr);
        frame_len = 2 + int'(lfsr % 16'h0007);
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd_reg(STATUS_ADDR);
        `CHK("status reset", 32'h00000000, rd)
        rd_reg(8'h20);
        `CHK("unmapped", 32'h00000000, rd)
        lane_init_done <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd_reg(STATUS_ADDR);
        `CHK("lane up", 32'h00000100, rd)
        channel_init_done <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd_reg(STATUS_ADDR);
        `CHK("link up", 32'h00000101, rd)
        wr(INT_MASK_ADDR, 32'h00000000);
        wr(FRAME_LEN_ADDR, frame_len);
        wr(CTRL_ADDR, 32'h00000200);
        repeat (20) @(posedge clk_sys);
        for (k = 0; k < 9; k++) send(k[3:0]);
        send(HALT_CODE);
        rd_reg(CTRL_ADDR);
        `CHK("last code", HALT_CODE, rd[3:0])
        // Reserved code must never reach the link
        wr(CTRL_ADDR, 32'h00000309);
        repeat (10) @(posedge clk_sys);
        for (k = 1; k < 9; k++) begin
            recv(k[3:0]);
            idles(1 << k);
        end
        rd_reg(STATUS_ADDR);
        `CHK("status code", 4'h8, rd[7:4])
        recv(HALT_CODE);
        repeat (3) @(posedge clk_sys);
        low = 0;
        repeat (40) begin
            @(posedge clk_sys);
            #1;
            if (fc.tx_accept_ready === 1'b0) low++;
        end
        `CHK("halted", 40, low)
        recv(RESUME_CODE);
        idles(0);
        @(posedge clk_sys);
        link_error_detect <= 1'b1;
        @(posedge clk_sys);
        link_error_detect <= 1'b0;
        #1;
        `CHK("frame err", 1'b1, fc.framing_error_pulse)
        `CHK("irq masked", 1'b0, irq)
        wr(INT_MASK_ADDR, 32'h00000007);
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK("irq set", 1'b1, irq)
        rd_reg(INT_STATUS_ADDR);
        `CHK("events", 32'h00000007, rd)
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK("irq clear", 1'b0, irq)
        rd_reg(INT_STATUS_ADDR);
        `CHK("events clear", 32'h00000000, rd)
        wrap_up();
    end
endmodule : native_flow_control_port_bench
